// file: icc_pkg.sv
// package: chip configuration word layout and shared constants
package icc_pkg;
  // ****************************************
  // word and staging layout
  // ****************************************
  localparam int CFG_W = 32;            // configuration word width
  localparam int BYTE_W = 8;            // master staging byte width
  localparam int NBYTES = 4;            // bytes per word
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // value after reset
  localparam logic [31:0] CFG_RSVD_MASK = 32'hFFE0_0000; // bits 31..21
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_NCO_SYNC = 20;       // carrier external sync enable
  localparam int B_DEC_SYNC = 19;       // decimation external sync enable
  localparam int B_FMT = 18;            // input format
  localparam int B_MODE = 17;           // input mode
  localparam int SG_HI = 16;            // shift gain msb
  localparam int SG_LO = 13;            // shift gain lsb
  localparam int DEC_HI = 12;           // decimation preload msb
  localparam int DEC_LO = 7;            // decimation preload lsb
  localparam int B_BYPASS = 6;          // filter bypass
  localparam int OFB_HI = 5;            // offset length msb
  localparam int OFB_LO = 4;            // offset length lsb
  localparam int B_SYNCSEL = 3;         // sync output clock select
  localparam int B_CLR_ACC = 2;         // clear phase accumulator
  localparam int B_OFS_EN = 1;          // offset frequency enable
  localparam int B_LOAD_ZERO = 0;       // zero feedback on carrier load
  localparam int B_BE_SYNC_RST = 22;    // back-end word: sync resets all
  localparam logic [4:0] SG_MAX = 5'h0F; // shift saturation
  localparam logic [5:0] DEC_MIN = 6'h03; // factor 4 minus one
  localparam logic [5:0] DEC_MAX = 6'h1F; // factor 32 minus one
  // ****************************************
  // host register map (designer's own)
  // ****************************************
  localparam logic [3:0] A_DATA = 4'h0; // not decoded by the host; writes ignored, reads zero
  localparam logic [3:0] A_CMD = 4'h1;  // commit/select byte count
  localparam logic [3:0] A_STAT = 4'h2; // status read
  localparam logic [3:0] A_CFG = 4'h3;  // read back last word sent
endpackage : icc_pkg

// file: icc_if.sv
// interface: byte-wise configuration link between host and device
`timescale 1ns/100ps
`default_nettype none
interface icc_if;
  logic [7:0] wr_byte;   // staging byte
  logic byte_stb;        // byte strobe into master register
  logic load_stb;        // transfer master register to config word
  logic clk_run;         // front-end clock present
  modport dev (input wr_byte, input byte_stb, input load_stb,
               output clk_run);
  modport host (output wr_byte, output byte_stb, output load_stb,
                input clk_run);
endinterface : icc_if
`default_nettype wire

// file: icc_sat_add.sv
// module: saturating shift-gain adder
`timescale 1ns/100ps
`default_nettype none
module icc_sat_add
  import icc_pkg::*;
(
  // operands
  input wire logic [3:0] field,
  input wire logic [2:0] pins,
  // result
  output logic [3:0] sum
);
  logic [4:0] raw; // unsaturated sum
  // ****************************************
  // add and clamp
  // ****************************************
  always_comb begin
    raw = {1'b0, field} + {2'b00, pins};
    sum = (raw > SG_MAX) ? 4'hF : raw[3:0];
  end
endmodule : icc_sat_add
`default_nettype wire

// file: icc_device.sv
// module: device end, chip configuration word and its effects
`timescale 1ns/100ps
`default_nettype none
module icc_device
  import icc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration link
  icc_if.dev link,
  // pins
  input wire logic clk_present,
  input wire logic ext_sync_in,
  input wire logic [2:0] gain_adjust_pins,
  input wire logic input_sample_enable,
  input wire logic offset_freq_serial_data,
  input wire logic offset_freq_serial_frame,
  // other control words feeding this block
  input wire logic [31:0] center_freq_hold,
  input wire logic [15:0] phase_hold,
  input wire logic cw5_write,
  input wire logic freq_write,
  input wire logic [31:0] back_end_config_word,
  // sample path
  input wire logic [13:0] sample_in,
  input wire logic [37:0] shifter_out,
  // decoded configuration
  output logic [31:0] cfg_word,
  output logic [13:0] sample_tc,
  output logic interp_mode,
  output logic [3:0] total_shift,
  output logic [5:0] dec_count,
  output logic dec_valid,
  output logic bypass,
  output logic [23:0] bypass_data,
  output logic syncout_sel_be,
  // carrier oscillator
  output logic [31:0] center_freq_act,
  output logic [15:0] phase_act,
  output logic [31:0] offset_freq,
  output logic [31:0] phase_acc,
  output logic full_reset
);
  logic [31:0] stage_q;   // master staging register
  logic [31:0] cfg_q;     // active configuration word
  logic sync_pend_q;      // external load waiting for oscillator update
  logic cpu_pend_q;       // processor load waiting for update
  logic [5:0] dec_q;      // decimation counter
  logic [31:0] ofs_shift_q; // offset serial shift register
  logic [31:0] ofs_q;     // captured offset
  logic [31:0] fc_q;      // active center frequency
  logic [15:0] ph_q;      // active phase
  logic [31:0] acc_q;     // phase accumulator
  logic [13:0] samp_q;    // converted sample
  logic [23:0] byp_q;     // bypass data
  logic nco_upd;          // oscillator advances this cycle
  logic do_load;          // apply held frequency/phase
  logic zero_fb;          // feedback forced to zero
  logic [5:0] ofs_bits;   // selected offset length
  logic [31:0] fb;        // accumulator feedback
  assign link.clk_run = clk_present;
  assign nco_upd = input_sample_enable;
  // ****************************************
  // byte staging and atomic load
  // ****************************************
  // staging shifts in bytes, low byte last; load copies the word with reserved bits 31..21 cleared
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_q <= CFG_RESET;
    end else if (link.byte_stb && clk_present) begin
      stage_q <= {stage_q[23:0], link.wr_byte};
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (link.load_stb && clk_present) begin
      cfg_q <= stage_q & ~CFG_RSVD_MASK;
    end
  end
  assign cfg_word = cfg_q;
  // ****************************************
  // input section
  // ****************************************
  // offset binary flips msb into two's complement
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      samp_q <= 14'h0000;
    end else begin
      samp_q <= cfg_q[B_FMT] ? {~sample_in[13], sample_in[12:0]}
                             : sample_in;
    end
  end
  assign sample_tc = samp_q;
  assign interp_mode = cfg_q[B_MODE];
  icc_sat_add u_gain (
    .field(cfg_q[SG_HI:SG_LO]),
    .pins(gain_adjust_pins),
    .sum(total_shift)
  );
  // ****************************************
  // decimation counter and bypass
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || full_reset) begin
      dec_q <= 6'h00;
    end else if (ext_sync_in && cfg_q[B_DEC_SYNC]) begin
      dec_q <= cfg_q[DEC_HI:DEC_LO];
    end else if (input_sample_enable) begin
      dec_q <= (dec_q == 6'h00) ? cfg_q[DEC_HI:DEC_LO] : dec_q - 6'h01;
    end
  end
  assign dec_count = dec_q;
  assign dec_valid = (cfg_q[DEC_HI:DEC_LO] >= DEC_MIN) &&
                     (cfg_q[DEC_HI:DEC_LO] <= DEC_MAX);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      byp_q <= 24'h000000;
    end else if (cfg_q[B_BYPASS]) begin
      byp_q <= shifter_out[23:0];
    end
  end
  assign bypass = cfg_q[B_BYPASS];
  assign bypass_data = byp_q;
  assign syncout_sel_be = cfg_q[B_SYNCSEL];
  // sync with the back-end reset bit clears both halves
  assign full_reset = ext_sync_in &&
                      back_end_config_word[B_BE_SYNC_RST];
  // ****************************************
  // offset frequency serial load
  // ****************************************
  always_comb begin
    case (cfg_q[OFB_HI:OFB_LO])
      2'b00: ofs_bits = 6'h08;
      2'b01: ofs_bits = 6'h10;
      2'b10: ofs_bits = 6'h18;
      default: ofs_bits = 6'h20;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ofs_shift_q <= 32'h0000_0000;
      ofs_q <= 32'h0000_0000;
    end else if (offset_freq_serial_frame) begin
      ofs_q <= ofs_shift_q << (6'h20 - ofs_bits);
      ofs_shift_q <= 32'h0000_0000;
    end else begin
      ofs_shift_q <= {ofs_shift_q[30:0], offset_freq_serial_data};
    end
  end
  assign offset_freq = cfg_q[B_OFS_EN] ? ofs_q : 32'h0000_0000;
  // ****************************************
  // carrier load pending and accumulator
  // ****************************************
  // loads wait for an enabled oscillator update
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_pend_q <= 1'b0;
      cpu_pend_q <= 1'b0;
    end else begin
      sync_pend_q <= (ext_sync_in && cfg_q[B_NCO_SYNC]) ||
                     (sync_pend_q && !nco_upd);
      cpu_pend_q <= cw5_write || freq_write || (cpu_pend_q && !nco_upd);
    end
  end
  assign do_load = nco_upd && (sync_pend_q || cpu_pend_q);
  assign zero_fb = cfg_q[B_CLR_ACC] ||
                   (do_load && cfg_q[B_LOAD_ZERO]);
  assign fb = zero_fb ? 32'h0000_0000 : acc_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || full_reset) begin
      fc_q <= 32'h0000_0000;
      ph_q <= 16'h0000;
    end else if (do_load) begin
      fc_q <= center_freq_hold;
      ph_q <= phase_hold;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || full_reset) begin
      acc_q <= 32'h0000_0000;
    end else if (nco_upd || zero_fb) begin
      acc_q <= fb + (nco_upd ? fc_q + offset_freq : 32'h0000_0000);
    end
  end
  assign center_freq_act = fc_q;
  assign phase_act = ph_q;
  assign phase_acc = acc_q;
endmodule : icc_device
`default_nettype wire

// file: icc_host.sv
// module: host end, loads the configuration word byte-wise
`timescale 1ns/100ps
`default_nettype none
module icc_host
  import icc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // software port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // configuration link
  icc_if.host link
);
  typedef enum {ST_IDLE, ST_SEND, ST_LOAD} icc_st_t;
  icc_st_t st_q;          // sequencer state
  logic [31:0] word_q;    // word being sent
  logic [2:0] left_q;     // bytes still to send
  logic [7:0] byte_q;     // byte on link
  logic bstb_q;           // byte strobe
  logic lstb_q;           // load strobe
  logic [31:0] rdata_q;   // read data
  logic [31:0] shadow_q;  // copy of the device staging register
  logic [7:0] nxt_byte;   // byte picked for this send cycle
  logic short_ok;         // two bytes leave the live upper fields intact
  // ****************************************
  // frame length choice
  // ****************************************
  // byte picked by the count still to send, msb first
  always_comb begin
    case (left_q)
      3'h4: nxt_byte = word_q[31:24];
      3'h3: nxt_byte = word_q[23:16];
      3'h2: nxt_byte = word_q[15:8];
      default: nxt_byte = word_q[7:0];
    endcase
  end
  // device staging keeps older bytes, so a two-byte frame puts the old
  // low half into bits 31:16; only safe when live fields there match.
  // a frame cut by a lost front-end clock leaves the shadow stale
  assign short_ok = ((shadow_q[15:0] ^ wdata[31:16]) &
                     ~CFG_RSVD_MASK[31:16]) == 16'h0000;
  // ****************************************
  // sequencer: sends msb byte first, then loads
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      word_q <= CFG_RESET;
      left_q <= 3'h0;
      byte_q <= 8'h00;
      bstb_q <= 1'b0;
      lstb_q <= 1'b0;
      shadow_q <= CFG_RESET;
    end else begin
      bstb_q <= 1'b0;
      lstb_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (wr && addr == A_CMD && link.clk_run) begin
            word_q <= wdata & ~CFG_RSVD_MASK;
            left_q <= short_ok ? 3'h2 : 3'h4;
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          byte_q <= nxt_byte;
          shadow_q <= {shadow_q[23:0], nxt_byte};
          bstb_q <= 1'b1;
          left_q <= left_q - 3'h1;
          if (left_q == 3'h1) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          lstb_q <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign link.wr_byte = byte_q;
  assign link.byte_stb = bstb_q;
  assign link.load_stb = lstb_q;
  // ****************************************
  // read port, data one cycle after strobe
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        A_STAT: rdata_q <= {30'h0, link.clk_run, st_q != ST_IDLE};
        A_CFG: rdata_q <= word_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign rdata = rdata_q;
endmodule : icc_host
`default_nettype wire

// file: icc_checker.sv
// checker: watches the host-to-device configuration link
`timescale 1ns/100ps
`default_nettype none
module icc_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link signals
  input wire logic [7:0] wr_byte,
  input wire logic byte_stb,
  input wire logic load_stb,
  input wire logic clk_run
);
  // ****************************************
  // frame shapes
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // two bytes then one load
  sequence s_two;
    byte_stb [*2] ##1 load_stb;
  endsequence
  // four bytes then one load
  sequence s_four;
    byte_stb [*4] ##1 load_stb;
  endsequence
  // ****************************************
  // link properties
  // ****************************************
  a_frame_len: assert property (
    $rose(byte_stb) |-> (s_two or s_four))
    else $error("link frame is neither two nor four bytes");
  a_run_max: assert property (byte_stb [*4] |=> !byte_stb)
    else $error("more than four bytes in one frame");
  a_rsvd_zero: assert property (($rose(byte_stb) && wr_byte[7:5] != 3'h0)
    |-> s_two)
    else $error("reserved top bits sent nonzero");
  a_no_clk: assert property (
    !clk_run |-> !byte_stb && !load_stb)
    else $error("link strobe without front-end clock");
  a_stb_excl: assert property (!(byte_stb && load_stb))
    else $error("byte and load strobe together");
  a_load_cause: assert property (load_stb |-> $past(byte_stb))
    else $error("load without preceding byte");
  a_load_once: assert property (load_stb |=> !load_stb)
    else $error("load strobe longer than one cycle");
  a_gap_after: assert property (
    load_stb |=> !byte_stb ##1 !byte_stb)
    else $error("new frame too soon after load");
endmodule : icc_checker
`default_nettype wire

// file: tb.sv
// testbench: host and device ends joined over the link
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb
  import icc_pkg::*;
;
  // software port and device pins
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0, clk_present = 1, sync = 0;
  logic ise = 0, full_reset, interp_mode, bypass, syncout_sel_be;
  logic cw5 = 0, fw = 0, ofd = 0, ofr = 0, dec_valid;
  logic [5:0] dec_count;
  logic [31:0] offset_freq;
  logic [3:0] addr = 0, total_shift;
  logic [2:0] gpins = 0;
  logic [13:0] smp = 0, sample_tc;
  logic [37:0] shf = 0;
  logic [15:0] ph_hold = 0, phase_act;
  logic [23:0] bypass_data;
  logic [31:0] wdata = 0, rdata, cfg_word, be_word = 0, cf_hold = 0;
  logic [31:0] center_freq_act, phase_acc, w, exp_v, prev_cfg = 0;
  logic [4:0] s;
  logic rd_seen = 0;
  logic [31:0] q_cfg[$], q_rd[$]; // expected notes
  int n_fail = 0, n_compared = 0, seed = 14;
  icc_if link();
  icc_host u_icc_host (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  icc_device u_icc_device (.mclk(mclk), .rst_n(rst_n), .link(link),
    .clk_present(clk_present), .ext_sync_in(sync), .gain_adjust_pins(gpins),
    .input_sample_enable(ise), .offset_freq_serial_data(ofd),
    .offset_freq_serial_frame(ofr), .center_freq_hold(cf_hold),
    .phase_hold(ph_hold), .cw5_write(cw5), .freq_write(fw),
    .back_end_config_word(be_word), .sample_in(smp), .shifter_out(shf),
    .cfg_word(cfg_word), .sample_tc(sample_tc), .interp_mode(interp_mode),
    .total_shift(total_shift), .dec_count(dec_count),
    .dec_valid(dec_valid), .bypass(bypass),
    .bypass_data(bypass_data), .syncout_sel_be(syncout_sel_be),
    .center_freq_act(center_freq_act), .phase_act(phase_act),
    .offset_freq(offset_freq), .phase_acc(phase_acc),
    .full_reset(full_reset));
  icc_checker u_icc_checker (.mclk(mclk), .rst_n(rst_n),
    .wr_byte(link.wr_byte), .byte_stb(link.byte_stb),
    .load_stb(link.load_stb), .clk_run(link.clk_run));
  // clock, 8 ns
  initial forever #4 mclk = ~mclk;
  // monitor: read data and word updates against oldest note
  always @(posedge mclk) begin
    if (rd_seen) begin
      exp_v = q_rd.pop_front();
      `CHK(rdata, exp_v)
    end
    if (rst_n && cfg_word !== prev_cfg) begin
      exp_v = q_cfg.pop_front();
      `CHK(cfg_word, exp_v)
    end
    prev_cfg = cfg_word;
    rd_seen = rd;
  end
  // one software cycle, write or read
  task sw(input logic [3:0] a, input logic [31:0] d, input logic w_n);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w_n;
    rd <= ~w_n;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : sw
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    sw(a, 32'h0, 1'b0);
  endtask : rd_chk
  // send a word and wait out the transfer
  task cfg_wr(input logic [31:0] d, input logic [31:0] e);
    q_cfg.push_back(e);
    sw(A_CMD, d, 1'b1);
    repeat (10) @(posedge mclk);
  endtask : cfg_wr
  // shift gain the host should pick for decimation r, 14 input bits
  function automatic logic [3:0] sg_for(input int r);
    real v;
    int n;
    v = 39.0 - 14.0 - 5.0 * $ln(r) / $ln(2.0) + 0.000001;
    n = int'($floor(v));
    if (r == 4) n = 15;
    if (r == 32) n = 0;
    return n[3:0];
  endfunction : sg_for
  task end_sim;
    if (q_cfg.size() != 0 || q_rd.size() != 0) n_fail++;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(A_CFG, 32'h0);
    rd_chk(A_STAT, 32'h2);
    rd_chk(4'h9, 32'h0);
    ise <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      w = $random(seed) & ~CFG_RSVD_MASK;
      w[12:7] = DEC_MIN + {2'h0, w[10:7]};
      w[16:13] = sg_for(int'(w[12:7]) + 1);
      gpins <= 3'($random(seed));
      smp <= 14'($random(seed));
      shf <= 38'($random(seed));
      cfg_wr(w, w);
      s = {1'b0, w[16:13]} + {2'h0, gpins};
      `CHK(interp_mode, w[B_MODE])
      `CHK(bypass, w[B_BYPASS])
      `CHK(syncout_sel_be, w[B_SYNCSEL])
      `CHK(total_shift, (s > SG_MAX) ? 4'hF : s[3:0])
      `CHK(sample_tc, smp ^ {w[B_FMT], 13'h0})
      if (w[B_BYPASS]) `CHK(bypass_data, shf[23:0])
      `CHK(dec_valid, 1'b1)
      // bypassed: samples at most every other clock; the loop drops the enable for one clock only
      if (w[B_BYPASS]) begin
        ise <= 1'b0;
        @(posedge mclk);
        ise <= 1'b1;
      end
    end
    rd_chk(A_CFG, w);
    cfg_wr(32'h0001_A5C3, 32'h0001_A5C3);
    cfg_wr(32'h0000_3C81, 32'h0000_3C81);
    cfg_wr(32'h0001_3C81, 32'h0001_3C81);
    cfg_wr(32'hFFF1_0000, 32'h0011_0000);
    q_cfg.push_back(32'h0004_0000);
    sw(A_CMD, 32'h0004_0000, 1'b1);
    sw(A_CMD, 32'h0002_0000, 1'b1);
    repeat (10) @(posedge mclk);
    clk_present <= 1'b0;
    sw(A_CMD, 32'h0008_0040, 1'b1);
    rd_chk(A_STAT, 32'h0);
    repeat (10) @(posedge mclk);
    clk_present <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      ise <= 1'b0;
      cfg_wr(e ? 32'h0010_0001 : 32'h0000_0001, e ? 32'h0010_0001 : 32'h1);
      cf_hold <= $random(seed);
      ph_hold <= 16'($random(seed));
      @(posedge mclk);
      sync <= 1'b1;
      @(posedge mclk);
      sync <= 1'b0;
      `CHK(full_reset, 1'b0)
      repeat (4) @(posedge mclk);
      `CHK(center_freq_act, 32'h0)
      ise <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK(center_freq_act, e ? cf_hold : 32'h0)
      `CHK(phase_act, e ? ph_hold : 16'h0)
      `CHK(phase_acc, e ? cf_hold + cf_hold : 32'h0)
    end
    cfg_wr(32'h0000_0004, 32'h0000_0004);
    `CHK(phase_acc, cf_hold)
    // offset word of each length, msb first, then frame strobe
    for (int l = 0; l < 4; l++) begin
      w = $random(seed);
      cfg_wr({26'h0, 2'(l), 4'h2}, {26'h0, 2'(l), 4'h2});
      for (int i = 8 * l + 7; i >= 0; i--) begin
        ofd <= w[i];
        @(posedge mclk);
      end
      ofd <= 1'b0;
      ofr <= 1'b1;
      @(posedge mclk);
      ofr <= 1'b0;
      @(posedge mclk);
      `CHK(offset_freq, w << (24 - 8 * l))
    end
    // carrier loads by sync, word 5 and frequency write, bit 0 set
    cfg_wr(32'h0010_0001, 32'h0010_0001);
    for (int k = 0; k < 3; k++) begin
      w = cf_hold;
      cf_hold <= $random(seed);
      repeat (3) @(posedge mclk);
      `CHK(center_freq_act, w)
      sync <= (k == 0);
      cw5 <= (k == 1);
      fw <= (k == 2);
      @(posedge mclk);
      sync <= 1'b0;
      cw5 <= 1'b0;
      fw <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(phase_acc, w)
      `CHK(center_freq_act, cf_hold)
    end
    cfg_wr(32'h0008_0F80, 32'h0008_0F80);
    `CHK(offset_freq, 32'h0)
    `CHK(dec_valid, 1'b1)
    sync <= 1'b1;
    @(posedge mclk);
    sync <= 1'b0;
    @(posedge mclk);
    `CHK(dec_count, DEC_MAX)
    cfg_wr(32'h0000_0000, 32'h0000_0000);
    `CHK(dec_valid, 1'b0)
    be_word <= 32'h0040_0000;
    sync <= 1'b1;
    @(posedge mclk);
    `CHK(full_reset, 1'b1)
    end_sim();
  end
endmodule : tb
`default_nettype wire
